//--- hw/gpm_pkg.sv
// package: register map, mode codes and timing constants of the port mode block
`default_nettype none
package gpm_pkg;
    localparam int NUM_PORTS = 6;
    localparam int PORT_WIDTH = 8;
    localparam int NUM_PINS = 43;
    localparam int LAST_PORT_PINS = 7;
    // register kinds, one word each; byte address = kind + port*4
    localparam logic [7:0] KIND_DATA = 8'h00;
    localparam logic [7:0] KIND_MODE_LOW = 8'h20;
    localparam logic [7:0] KIND_MODE_HIGH = 8'h40;
    localparam logic [7:0] KIND_THRESHOLD = 8'h60;
    localparam logic [7:0] KIND_SLEW = 8'h80;
    localparam logic [7:0] ADDR_LIMIT = 8'hA0;
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [7:0] MODE_LOW_RESET = 8'hFF;
    localparam logic [7:0] MODE_HIGH_RESET = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;
    localparam logic [7:0] SLEW_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOOST_CYCLES = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {GPM_QUASI, GPM_PUSH_PULL, GPM_INPUT_ONLY, GPM_OPEN_DRAIN} gpm_mode_e;

    // per-pin drive controls towards the pad
    typedef struct packed {
        logic strongLow;
        logic strongHigh;
        logic weakHigh;
        logic fastSlew;
        logic schmitt;
    } gpm_pad_s;
endpackage
`default_nettype wire

//--- hw/gpm_sync.sv
// module: two-flop synchroniser for a vector of pin levels
`default_nettype none
module gpm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_syncOut;

    always_comb
    begin
        next_stage1 = asyncIn;
        next_syncOut = stage1;
    end

    // first stage is read only by the second
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stage1 <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1 <= next_stage1;
            syncOut <= next_syncOut;
        end
    end
endmodule
`default_nettype wire

//--- hw/gpm_pin.sv
// module: drive decode and strong pull-high pulse for one pin
`default_nettype none
module gpm_pin (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic latchBit,
    input wire logic modeLow,
    input wire logic modeHigh,
    input wire logic thresholdBit,
    input wire logic slewBit,
    output gpm_pkg::gpm_pad_s pad
);
    logic prevLatch;
    logic [1:0] boostCount;
    logic next_prevLatch;
    logic [1:0] next_boostCount;
    gpm_pkg::gpm_pad_s next_pad;
    gpm_pkg::gpm_mode_e mode;

    always_comb
    begin
        mode = gpm_pkg::gpm_mode_e'({modeLow, modeHigh});
        next_prevLatch = latchBit;
        next_boostCount = (boostCount != 2'h0) ? boostCount - 2'h1 : 2'h0;
        // a rising latch in quasi mode arms a two-cycle strong pull-high
        if (mode == gpm_pkg::GPM_QUASI && latchBit && !prevLatch)
        begin
            next_boostCount = 2'(gpm_pkg::BOOST_CYCLES);
        end
        if (mode != gpm_pkg::GPM_QUASI || !latchBit)
        begin
            next_boostCount = 2'h0;
        end
        next_pad = '0;
        next_pad.fastSlew = slewBit;
        next_pad.schmitt = thresholdBit;
        case (mode)
            gpm_pkg::GPM_QUASI:
            begin
                next_pad.weakHigh = latchBit;
                next_pad.strongLow = !latchBit;
                next_pad.strongHigh = (next_boostCount != 2'h0);
            end
            gpm_pkg::GPM_PUSH_PULL:
            begin
                next_pad.strongHigh = latchBit;
                next_pad.strongLow = !latchBit;
            end
            gpm_pkg::GPM_OPEN_DRAIN:
            begin
                next_pad.strongLow = !latchBit;
            end
            default:
            begin
                next_pad.strongLow = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            prevLatch <= 1'b1;
            boostCount <= 2'h0;
            pad <= '0;
        end
        else
        begin
            prevLatch <= next_prevLatch;
            boostCount <= next_boostCount;
            pad <= next_pad;
        end
    end
endmodule
`default_nettype wire

//--- hw/gpm_port.sv
// module: general purpose port block with AXI4-Lite register access
`default_nettype none
module gpm_port #(
    parameter int NUM_PORTS = gpm_pkg::NUM_PORTS,
    parameter int NUM_PINS = gpm_pkg::NUM_PINS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_PINS-1:0] pinIn,
    output gpm_pkg::gpm_pad_s [NUM_PINS-1:0] padCtrl
);
    localparam int PW = gpm_pkg::PORT_WIDTH;
    localparam int FULL = NUM_PORTS * PW;

    // ************************************************************
    // register storage
    // ************************************************************
    logic [FULL-1:0] dataLatch, modeLow, modeHigh, threshold, slew;
    logic [FULL-1:0] next_dataLatch, next_modeLow, next_modeHigh, next_threshold, next_slew;
    logic [NUM_PINS-1:0] pinSync;
    logic [FULL-1:0] pinLevel;

    // sixth port is narrower: absent pins read zero (one in mode low) and are not driven
    function automatic logic [FULL-1:0] pinMask();
        logic [FULL-1:0] m;
        m = '0;
        m[NUM_PINS-1:0] = '1;
        return m;
    endfunction

    // decode a byte address to its register kind and port index
    // unaligned or out-of-range offsets miss every kind and answer with an error
    function automatic logic addrHit(input logic [31:0] a, input logic [7:0] kind,
                                     output int port);
        logic [7:0] off;
        off = a[7:0] - kind;
        port = int'(off[4:2]);
        return (a[31:8] == 24'h0) && (a[7:0] >= kind) && (off < 8'h20)
            && (off[1:0] == 2'h0) && (port < NUM_PORTS);
    endfunction

    // ************************************************************
    // pin sampling and pad drive
    // ************************************************************
    // pins are asynchronous; reads see them three edges late, a cost paid
    // to keep a metastable level out of the read data
    gpm_sync #(.WIDTH(NUM_PINS)) uSync (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    always_comb
    begin
        pinLevel = '0;
        pinLevel[NUM_PINS-1:0] = pinSync;
    end

    // each pin registers its own drive, so every pad output comes from a flop
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : gPin
            gpm_pin uPin (
                .clk(clk),
                .reset_n(reset_n),
                .latchBit(dataLatch[g]),
                .modeLow(modeLow[g]),
                .modeHigh(modeHigh[g]),
                .thresholdBit(threshold[g]),
                .slewBit(slew[g]),
                .pad(padCtrl[g])
            );
        end
    endgenerate

    // ************************************************************
    // write channel
    // ************************************************************
    // address and data may arrive in either order; each is held until both are in
    logic awHeld, wHeld;
    logic [31:0] awAddr, wData;
    logic [3:0] wStrb;
    logic next_awHeld, next_wHeld, next_bvalid, next_awready, next_wready;
    logic [31:0] next_awAddr, next_wData;
    logic [3:0] next_wStrb;
    logic [1:0] next_bresp;

    always_comb
    begin
        int p;
        logic [7:0] b;
        p = 0;
        b = 8'h00;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_dataLatch = dataLatch;
        next_modeLow = modeLow;
        next_modeHigh = modeHigh;
        next_threshold = threshold;
        next_slew = slew;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        // the write lands on the edge that raises bvalid; a pending response
        // holds both readies low, so at most one write is ever in flight
        if (awHeld && wHeld && !s_axi_bvalid)
        begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = gpm_pkg::RESP_SLVERR;
            b = wData[7:0];
            // only byte lane 0 carries data; other lanes are ignored
            if (addrHit(awAddr, gpm_pkg::KIND_DATA, p))
            begin
                if (wStrb[0]) next_dataLatch[p*PW +: PW] = b;
                next_bresp = gpm_pkg::RESP_OKAY;
            end
            else if (addrHit(awAddr, gpm_pkg::KIND_MODE_LOW, p))
            begin
                if (wStrb[0]) next_modeLow[p*PW +: PW] = b;
                next_bresp = gpm_pkg::RESP_OKAY;
            end
            else if (addrHit(awAddr, gpm_pkg::KIND_MODE_HIGH, p))
            begin
                if (wStrb[0]) next_modeHigh[p*PW +: PW] = b;
                next_bresp = gpm_pkg::RESP_OKAY;
            end
            else if (addrHit(awAddr, gpm_pkg::KIND_THRESHOLD, p))
            begin
                if (wStrb[0]) next_threshold[p*PW +: PW] = b;
                next_bresp = gpm_pkg::RESP_OKAY;
            end
            else if (addrHit(awAddr, gpm_pkg::KIND_SLEW, p))
            begin
                if (wStrb[0]) next_slew[p*PW +: PW] = b;
                next_bresp = gpm_pkg::RESP_OKAY;
            end
        end
        // absent pins are forced to input-only with a zero latch every cycle,
        // so no write can ever make them drive
        next_dataLatch = next_dataLatch & pinMask();
        next_modeLow = next_modeLow | ~pinMask();
        next_modeHigh = next_modeHigh & pinMask();
        next_threshold = next_threshold & pinMask();
        next_slew = next_slew & pinMask();
        next_awready = !next_awHeld && !next_bvalid;
        next_wready = !next_wHeld && !next_bvalid;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpm_pkg::RESP_OKAY;
            // absent pins leave reset with ones in data and mode low, zeros elsewhere, and are masked on the first edge
            dataLatch <= {NUM_PORTS{gpm_pkg::DATA_RESET}};
            modeLow <= {NUM_PORTS{gpm_pkg::MODE_LOW_RESET}};
            modeHigh <= {NUM_PORTS{gpm_pkg::MODE_HIGH_RESET}};
            threshold <= {NUM_PORTS{gpm_pkg::THRESHOLD_RESET}};
            slew <= {NUM_PORTS{gpm_pkg::SLEW_RESET}};
        end
        else
        begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            dataLatch <= next_dataLatch;
            modeLow <= next_modeLow;
            modeHigh <= next_modeHigh;
            threshold <= next_threshold;
            slew <= next_slew;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    logic next_arready, next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    always_comb
    begin
        int p;
        p = 0;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        // arready stays low while rvalid waits, so a second read cannot
        // overwrite data the master has not yet taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = '0;
            next_rresp = gpm_pkg::RESP_OKAY;
            if (addrHit(s_axi_araddr, gpm_pkg::KIND_DATA, p))
                next_rdata[7:0] = pinLevel[p*PW +: PW];
            else if (addrHit(s_axi_araddr, gpm_pkg::KIND_MODE_LOW, p))
                next_rdata[7:0] = modeLow[p*PW +: PW];
            else if (addrHit(s_axi_araddr, gpm_pkg::KIND_MODE_HIGH, p))
                next_rdata[7:0] = modeHigh[p*PW +: PW];
            else if (addrHit(s_axi_araddr, gpm_pkg::KIND_THRESHOLD, p))
                next_rdata[7:0] = threshold[p*PW +: PW];
            else if (addrHit(s_axi_araddr, gpm_pkg::KIND_SLEW, p))
                next_rdata[7:0] = slew[p*PW +: PW];
            else
                next_rresp = gpm_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= gpm_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule
`default_nettype wire

//--- testbench/gpm_port_assertions.sv
// checker: bus handshake and pad drive assertions of the port mode block
`default_nettype none
module gpm_port_checker #(
    parameter int NUM_PINS = gpm_pkg::NUM_PINS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire gpm_pkg::gpm_pad_s [NUM_PINS-1:0] padCtrl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ****
    // register bus
    // ****
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
    busy_refuse_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    read_upper_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // ****
    // pad drive
    // ****
    // reset clears pads even while reset holds, so this one is never disabled
    reset_clear_a:
        assert property (@(posedge clk) disable iff (1'b0) !reset_n |=> padCtrl == '0)
        else $error("pads driven during reset");
    input_default_a:
        assert property ($rose(reset_n) |-> (padCtrl == '0) [*3])
        else $error("pads driven after reset");
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        no_fight_a:
            assert property (!(padCtrl[i].strongLow
                && (padCtrl[i].strongHigh || padCtrl[i].weakHigh)))
            else $error("pull-low and pull-high together");
        boost_len_a:
            assert property ($rose(padCtrl[i].weakHigh) && padCtrl[i].strongHigh
                |=> padCtrl[i].strongHigh ##1 !padCtrl[i].strongHigh)
            else $error("strong pull-high pulse length wrong");
    end
endmodule

bind gpm_port gpm_port_checker #(.NUM_PINS(NUM_PINS)) chk_i (
    .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .padCtrl(padCtrl)
);
`default_nettype wire

//--- testbench/gpm_pin_model.sv
// partner: outside circuit on the pins, resolving pad drive against external drivers
`default_nettype none
module gpm_pin_model #(
    parameter int NUM_PINS = gpm_pkg::NUM_PINS
) (
    input wire logic clk,
    input wire gpm_pkg::gpm_pad_s [NUM_PINS-1:0] padCtrl,
    input wire logic [NUM_PINS-1:0] extEn,
    input wire logic [NUM_PINS-1:0] extVal,
    output logic [NUM_PINS-1:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // a floating pin flips every cycle so a stale level never reads as valid
    logic toggle = 1'b0;
    always @(posedge clk)
        toggle <= ~toggle;
    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (padCtrl[i].strongLow)
                pinIn[i] = 1'b0;
            else if (padCtrl[i].strongHigh)
                pinIn[i] = 1'b1;
            else if (extEn[i])
                pinIn[i] = extVal[i]; // outside device beats the weak pull
            else if (padCtrl[i].weakHigh)
                pinIn[i] = 1'b1;
            else
                pinIn[i] = toggle ^ i[0];
        end
    end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// bench: register access and pad drive checks of the port mode block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = gpm_pkg::NUM_PINS;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [NP-1:0] pinIn;
    logic [NP-1:0] extEn = '1;
    logic [47:0] extAll = 48'h0;
    gpm_pkg::gpm_pad_s [NP-1:0] padCtrl;
    logic [31:0] seed = 32'h0000_8234;
    logic [33:0] readQ[$];
    logic [1:0] writeQ[$];
    logic [3:0] drv;
    logic [3:0] modeTab [4] = '{4'h2, 4'h6, 4'h0, 4'h2};
    int bad_count = 0;
    int samples_checked = 0;
    int boostSeen = 0;
    int base;

    always #5 clk = ~clk;

    gpm_port dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pinIn(pinIn), .padCtrl(padCtrl));
    gpm_pin_model pins (.clk(clk), .padCtrl(padCtrl), .extEn(extEn), .extVal(extAll[NP-1:0]),
        .pinIn(pinIn));

    // ****
    // helpers
    // ****
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] r = gpm_pkg::RESP_OKAY);
        writeQ.push_back(r);
        awaddr <= {24'h0, a};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge clk);
        while (awvalid || wvalid)
        begin
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            @(posedge clk);
        end
        while (bvalid !== 1'b1)
            @(posedge clk);
    endtask

    task automatic axiRead(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] r = gpm_pkg::RESP_OKAY);
        readQ.push_back({r, 24'h0, d});
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        @(posedge clk);
        while (arready !== 1'b1)
            @(posedge clk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge clk);
    endtask

    task automatic results();
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // responses are taken off the queues in the order the requests were made
    always @(posedge clk)
    begin
        if (padCtrl[1].strongHigh === 1'b1)
            boostSeen++;
        if (rvalid === 1'b1 && rready)
        begin
            chk("rdata", readQ[0][31:0], rdata);
            chk("rresp", {30'h0, readQ[0][33:32]}, {30'h0, rresp});
            void'(readQ.pop_front());
        end
        if (bvalid === 1'b1 && bready)
        begin
            chk("bresp", {30'h0, writeQ[0]}, {30'h0, bresp});
            void'(writeQ.pop_front());
        end
    end

    initial
    begin
        #100us;
        bad_count++;
        results();
    end

    // ****
    // scenarios
    // ****
    initial
    begin
        seed = xorshift(seed);
        extAll[31:0] = seed;
        seed = xorshift(seed);
        extAll[47:32] = seed[15:0];
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("padsOff", 32'h0, {31'h0, |padCtrl});
        for (int p = 0; p < 6; p++)
            axiRead(8'(4 * p), extAll[8*p +: 8] & (p == 5 ? 8'h07 : 8'hFF));
        axiRead(gpm_pkg::KIND_MODE_LOW, gpm_pkg::MODE_LOW_RESET);
        axiRead(gpm_pkg::KIND_MODE_HIGH, gpm_pkg::MODE_HIGH_RESET);
        axiRead(gpm_pkg::KIND_THRESHOLD, gpm_pkg::THRESHOLD_RESET);
        axiRead(gpm_pkg::KIND_SLEW, gpm_pkg::SLEW_RESET);
        axiWrite(gpm_pkg::ADDR_LIMIT, 8'h00, gpm_pkg::RESP_SLVERR);
        axiRead(gpm_pkg::ADDR_LIMIT, 8'h00, gpm_pkg::RESP_SLVERR);
        axiRead(8'h21, 8'h00, gpm_pkg::RESP_SLVERR);
        wstrb <= 4'h0;
        axiWrite(gpm_pkg::KIND_MODE_LOW + 8'h08, 8'h00);
        wstrb <= 4'hF;
        axiRead(gpm_pkg::KIND_MODE_LOW + 8'h08, gpm_pkg::MODE_LOW_RESET);
        extEn <= '0;
        axiWrite(gpm_pkg::KIND_MODE_LOW, 8'h00);
        axiWrite(gpm_pkg::KIND_DATA, 8'hFC);
        repeat (2) @(posedge clk);
        chk("quasiLow", 32'h2, {30'h0, padCtrl[0].strongLow, padCtrl[0].weakHigh});
        base = boostSeen;
        axiWrite(gpm_pkg::KIND_DATA, 8'hFE);
        repeat (4) @(posedge clk);
        chk("boostLen", 32'(gpm_pkg::BOOST_CYCLES), 32'(boostSeen - base));
        extEn[1] <= 1'b1;
        extAll[1] <= 1'b0;
        repeat (4) @(posedge clk);
        axiRead(gpm_pkg::KIND_DATA, 8'hFC);
        extEn <= '0;
        for (int m = 0; m < 4; m++)
        begin
            axiWrite(gpm_pkg::KIND_MODE_LOW, m[1] ? 8'hFF : 8'h00);
            axiWrite(gpm_pkg::KIND_MODE_HIGH, m[0] ? 8'hFF : 8'h00);
            repeat (4) @(posedge clk);
            drv = {padCtrl[1].strongLow, padCtrl[1].strongHigh,
                padCtrl[0].strongLow, padCtrl[0].strongHigh};
            chk("modeDrive", {28'h0, modeTab[m]}, {28'h0, drv});
            if (m != 1)
                chk("weakHigh", {31'h0, m == 0}, {31'h0, padCtrl[1].weakHigh});
        end
        seed = xorshift(seed);
        axiWrite(gpm_pkg::KIND_THRESHOLD + 8'h04, seed[7:0]);
        axiWrite(gpm_pkg::KIND_SLEW + 8'h04, seed[15:8]);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            chk("schmitt", {31'h0, seed[i]}, {31'h0, padCtrl[8 + i].schmitt});
            chk("fastSlew", {31'h0, seed[8 + i]}, {31'h0, padCtrl[8 + i].fastSlew});
        end
        axiRead(gpm_pkg::KIND_SLEW + 8'h04, seed[15:8]);
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("padsReset", 32'h0, {31'h0, |padCtrl});
        axiRead(gpm_pkg::KIND_MODE_LOW + 8'h04, gpm_pkg::MODE_LOW_RESET);
        // let the monitor take the last answer before the verdict
        repeat (2) @(posedge clk);
        chk("pending", 32'h0, 32'(readQ.size() + writeQ.size()));
        results();
    end
endmodule
`default_nettype wire
